// >>> verilog/rvs_map.svh
// Register offsets, field positions and timing constants for the rail voltage select bank
`ifndef RVS_MAP_SVH
`define RVS_MAP_SVH
`define RVS_OFS_RAIL2_SLEEP_CONTROL 8'h93
`define RVS_OFS_RAIL4_NORMAL_CODE 8'h94
`define RVS_OFS_RAIL4_SLEEP_CODE 8'h95
`define RVS_OFS_RAIL5_NORMAL_CODE 8'h96
`define RVS_CODE_MSB 7
`define RVS_CODE_LSB 1
`define RVS_FLAG_BIT 0
`define RVS_PIN_SYNC_STAGES 3
`endif

// >>> verilog/rvs_pkg.sv
// Types shared by the rail voltage select bank
package rvs_pkg;
  typedef logic [6:0] rvs_code_t;
  typedef logic [7:0] rvs_byte_t;
  typedef enum logic {rvs_pin_first, rvs_pin_second} rvs_pin_sel_e;
  typedef enum logic {rvs_range_10mv, rvs_range_25mv} rvs_range_e;
endpackage

// >>> verilog/rvs_pin_if.sv
// Carrier between the pin synchroniser and the register bank
`timescale 1ns/100ps
`default_nettype none
interface rvs_pin_if;
  logic first_sleep_pin;
  logic second_sleep_pin;
  modport sync (output first_sleep_pin, output second_sleep_pin);
  modport bank (input first_sleep_pin, input second_sleep_pin);
endinterface
`default_nettype wire

// >>> verilog/rvs_pin_sync.sv
// Three-stage synchroniser for the two sleep pins
`timescale 1ns/100ps
`default_nettype none
module rvs_pin_sync
  import rvs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic first_sleep_pin_in,
  input wire logic second_sleep_pin_in,
  rvs_pin_if.sync pins
);
  typedef struct packed {
    logic [2:0] first_chain;
    logic [2:0] second_chain;
    logic first_level;
    logic second_level;
  } rvs_sync_s;

  rvs_sync_s state;
  rvs_sync_s next_state;

  // Shift chains; a level counts once stages two and three agree
  always_comb begin
    next_state = state;
    next_state.first_chain = {state.first_chain[1:0], first_sleep_pin_in};
    next_state.second_chain = {state.second_chain[1:0], second_sleep_pin_in};
    if (state.first_chain[1] == state.first_chain[2]) begin
      next_state.first_level = state.first_chain[2];
    end
    if (state.second_chain[1] == state.second_chain[2]) begin
      next_state.second_level = state.second_chain[2];
    end
  end

  // Pins idle high (not sleeping) out of reset
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '{first_chain: 3'h7, second_chain: 3'h7, first_level: 1'h1, second_level: 1'h1};
    end else begin
      state <= next_state;
    end
  end

  assign pins.first_sleep_pin = state.first_level;
  assign pins.second_sleep_pin = state.second_level;
endmodule
`default_nettype wire

// >>> verilog/rvs_bank.sv
// Rail voltage select register bank with sleep code selection
`timescale 1ns/100ps
`default_nettype none
`include "rvs_map.svh"
module rvs_bank
  import rvs_pkg::*;
#(
  parameter rvs_byte_t FACTORY_RAIL2_SLEEP_CONTROL = 8'h00,
  parameter rvs_byte_t FACTORY_RAIL4_NORMAL_CODE = 8'h00,
  parameter rvs_byte_t FACTORY_RAIL4_SLEEP_CODE = 8'h00,
  parameter rvs_byte_t FACTORY_RAIL5_NORMAL_CODE = 8'h00
)
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  input wire logic otp_load_in,
  input wire logic [7:0] otp_rail2_sleep_control_in,
  input wire logic [7:0] otp_rail4_normal_code_in,
  input wire logic [7:0] otp_rail4_sleep_code_in,
  input wire logic [7:0] otp_rail5_normal_code_in,
  input wire logic otp_sleep_pin_sel_in,
  input wire logic rail_two_range_25mv_in,
  input wire logic rail_four_range_25mv_in,
  input wire logic rail_five_range_25mv_in,
  input wire logic [6:0] rail_two_normal_code_in,
  input wire logic first_sleep_pin_in,
  input wire logic second_sleep_pin_in,
  input wire logic rail_four_sleep_active_in,
  output logic [6:0] rail_two_target_code_out,
  output logic rail_two_in_sleep_out,
  output logic [6:0] rail_four_normal_code_out,
  output logic [6:0] rail_four_sleep_code_out,
  output logic [6:0] rail_four_target_code_out,
  output logic rail_four_decay_select_out,
  output logic rail_four_range_25mv_out,
  output logic [6:0] rail_five_normal_code_out,
  output logic rail_five_decay_select_out,
  output logic rail_five_range_25mv_out,
  output logic rail_two_range_25mv_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    rvs_code_t rail_two_sleep_code;
    logic rail_two_sleep_enable;
    rvs_code_t rail_four_normal_code;
    logic rail_four_decay_select;
    rvs_code_t rail_four_sleep_code;
    rvs_code_t rail_five_normal_code;
    logic rail_five_decay_select;
    rvs_pin_sel_e pin_sel;
    rvs_range_e range_two;
    rvs_range_e range_four;
    rvs_range_e range_five;
    rvs_code_t rail_two_target;
    logic rail_two_in_sleep;
    rvs_code_t rail_four_target;
    rvs_byte_t rdata;
    logic hit;
  } rvs_bank_s;

  rvs_bank_s state;
  rvs_bank_s next_state;
  rvs_pin_if pins ();
  logic chosen_pin;
  logic sleep_now;

  // Pack a code and its low flag into a register byte
  function automatic rvs_byte_t pack_reg(input rvs_code_t code, input logic flag);
    pack_reg = {code, flag};
  endfunction

  // Code field of a written byte
  function automatic rvs_code_t code_of(input rvs_byte_t value);
    code_of = value[`RVS_CODE_MSB:`RVS_CODE_LSB];
  endfunction

  // ----------------------------------------
  // Sleep pin synchroniser
  // ----------------------------------------
  rvs_pin_sync u_pin_sync (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .first_sleep_pin_in(first_sleep_pin_in),
    .second_sleep_pin_in(second_sleep_pin_in),
    .pins(pins.sync)
  );

  // Factory pin choice picks the governing pin
  assign chosen_pin = (state.pin_sel == rvs_pin_second) ? pins.second_sleep_pin : pins.first_sleep_pin;
  assign sleep_now = state.rail_two_sleep_enable && !chosen_pin;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.hit = 1'h0;
    // Factory reload of codes and straps
    if (otp_load_in) begin
      next_state.rail_two_sleep_code = code_of(otp_rail2_sleep_control_in);
      next_state.rail_two_sleep_enable = otp_rail2_sleep_control_in[`RVS_FLAG_BIT];
      next_state.rail_four_normal_code = code_of(otp_rail4_normal_code_in);
      next_state.rail_four_decay_select = otp_rail4_normal_code_in[`RVS_FLAG_BIT];
      next_state.rail_four_sleep_code = code_of(otp_rail4_sleep_code_in);
      next_state.rail_five_normal_code = code_of(otp_rail5_normal_code_in);
      next_state.rail_five_decay_select = otp_rail5_normal_code_in[`RVS_FLAG_BIT];
      next_state.pin_sel = rvs_pin_sel_e'(otp_sleep_pin_sel_in);
      next_state.range_two = rvs_range_e'(rail_two_range_25mv_in);
      next_state.range_four = rvs_range_e'(rail_four_range_25mv_in);
      next_state.range_five = rvs_range_e'(rail_five_range_25mv_in);
    end else if (reg_wr_in) begin
      // Register writes
      case (reg_addr_in)
        `RVS_OFS_RAIL2_SLEEP_CONTROL: begin
          next_state.rail_two_sleep_code = code_of(reg_wdata_in);
          next_state.rail_two_sleep_enable = reg_wdata_in[`RVS_FLAG_BIT];
          next_state.hit = 1'h1;
        end
        `RVS_OFS_RAIL4_NORMAL_CODE: begin
          next_state.rail_four_normal_code = code_of(reg_wdata_in);
          next_state.rail_four_decay_select = reg_wdata_in[`RVS_FLAG_BIT];
          next_state.hit = 1'h1;
        end
        `RVS_OFS_RAIL4_SLEEP_CODE: begin
          next_state.rail_four_sleep_code = code_of(reg_wdata_in);
          next_state.hit = 1'h1;
        end
        `RVS_OFS_RAIL5_NORMAL_CODE: begin
          next_state.rail_five_normal_code = code_of(reg_wdata_in);
          next_state.rail_five_decay_select = reg_wdata_in[`RVS_FLAG_BIT];
          next_state.hit = 1'h1;
        end
        default: begin
          next_state.hit = 1'h0;
        end
      endcase
    end
    // Register reads, unmapped reads return zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        `RVS_OFS_RAIL2_SLEEP_CONTROL: begin
          next_state.rdata = pack_reg(state.rail_two_sleep_code, state.rail_two_sleep_enable);
          next_state.hit = 1'h1;
        end
        `RVS_OFS_RAIL4_NORMAL_CODE: begin
          next_state.rdata = pack_reg(state.rail_four_normal_code, state.rail_four_decay_select);
          next_state.hit = 1'h1;
        end
        `RVS_OFS_RAIL4_SLEEP_CODE: begin
          next_state.rdata = pack_reg(state.rail_four_sleep_code, 1'h0);
          next_state.hit = 1'h1;
        end
        `RVS_OFS_RAIL5_NORMAL_CODE: begin
          next_state.rdata = pack_reg(state.rail_five_normal_code, state.rail_five_decay_select);
          next_state.hit = 1'h1;
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end
    // Target code selection
    next_state.rail_two_in_sleep = sleep_now;
    next_state.rail_two_target = sleep_now ? state.rail_two_sleep_code : rail_two_normal_code_in;
    next_state.rail_four_target = rail_four_sleep_active_in ? state.rail_four_sleep_code : state.rail_four_normal_code;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= '{
        rail_two_sleep_code: FACTORY_RAIL2_SLEEP_CONTROL[`RVS_CODE_MSB:`RVS_CODE_LSB],
        rail_two_sleep_enable: FACTORY_RAIL2_SLEEP_CONTROL[`RVS_FLAG_BIT],
        rail_four_normal_code: FACTORY_RAIL4_NORMAL_CODE[`RVS_CODE_MSB:`RVS_CODE_LSB],
        rail_four_decay_select: FACTORY_RAIL4_NORMAL_CODE[`RVS_FLAG_BIT],
        rail_four_sleep_code: FACTORY_RAIL4_SLEEP_CODE[`RVS_CODE_MSB:`RVS_CODE_LSB],
        rail_five_normal_code: FACTORY_RAIL5_NORMAL_CODE[`RVS_CODE_MSB:`RVS_CODE_LSB],
        rail_five_decay_select: FACTORY_RAIL5_NORMAL_CODE[`RVS_FLAG_BIT],
        pin_sel: rvs_pin_first,
        range_two: rvs_range_10mv,
        range_four: rvs_range_10mv,
        range_five: rvs_range_10mv,
        rail_two_target: 7'h00,
        rail_two_in_sleep: 1'h0,
        rail_four_target: 7'h00,
        rdata: 8'h00,
        hit: 1'h0
      };
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_out = state.rdata;
  assign reg_hit_out = state.hit;
  assign rail_two_target_code_out = state.rail_two_target;
  assign rail_two_in_sleep_out = state.rail_two_in_sleep;
  assign rail_four_normal_code_out = state.rail_four_normal_code;
  assign rail_four_sleep_code_out = state.rail_four_sleep_code;
  assign rail_four_target_code_out = state.rail_four_target;
  assign rail_four_decay_select_out = state.rail_four_decay_select;
  assign rail_five_normal_code_out = state.rail_five_normal_code;
  assign rail_five_decay_select_out = state.rail_five_decay_select;
  assign rail_two_range_25mv_out = (state.range_two == rvs_range_25mv);
  assign rail_four_range_25mv_out = (state.range_four == rvs_range_25mv);
  assign rail_five_range_25mv_out = (state.range_five == rvs_range_25mv);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_sleep_disabled_normal: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !$past(state.rail_two_sleep_enable) |-> !rail_two_in_sleep_out)
    else $error("rail two left normal code with sleep disabled");
  a_sleep_target_code: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    rail_two_in_sleep_out |-> rail_two_target_code_out == $past(state.rail_two_sleep_code))
    else $error("rail two sleep target does not match sleep code");
  a_sleep_pin_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($past(state.rail_two_sleep_enable) && !$past(chosen_pin)) |-> rail_two_in_sleep_out)
    else $error("rail two not in sleep with enable set and pin low");
  a_pin_sel_stable: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !$past(otp_load_in) |-> $stable(state.pin_sel))
    else $error("sleep pin choice changed without factory load");
  a_rail4_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (reg_wr_in && !otp_load_in && reg_addr_in == `RVS_OFS_RAIL4_NORMAL_CODE)
    |=> rail_four_normal_code_out == $past(reg_wdata_in[`RVS_CODE_MSB:`RVS_CODE_LSB])
    && rail_four_decay_select_out == $past(reg_wdata_in[`RVS_FLAG_BIT]))
    else $error("rail four normal write not stored");
  a_rail4_sleep_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (reg_wr_in && !otp_load_in && reg_addr_in == `RVS_OFS_RAIL4_SLEEP_CODE)
    |=> rail_four_sleep_code_out == $past(reg_wdata_in[`RVS_CODE_MSB:`RVS_CODE_LSB]))
    else $error("rail four sleep write not stored");
  a_rail5_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (reg_wr_in && !otp_load_in && reg_addr_in == `RVS_OFS_RAIL5_NORMAL_CODE)
    |=> rail_five_normal_code_out == $past(reg_wdata_in[`RVS_CODE_MSB:`RVS_CODE_LSB])
    && rail_five_decay_select_out == $past(reg_wdata_in[`RVS_FLAG_BIT]))
    else $error("rail five normal write not stored");
  a_reserved_reads_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (reg_rd_in && reg_addr_in == `RVS_OFS_RAIL4_SLEEP_CODE) |=> reg_rdata_out[`RVS_FLAG_BIT] == 1'h0 && reg_hit_out)
    else $error("reserved bit read back nonzero");
  a_otp_loads_range: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    otp_load_in |=> rail_two_range_25mv_out == $past(rail_two_range_25mv_in))
    else $error("factory range not loaded");
  c_enter_sleep: cover property (@(posedge mclk_in) disable iff (!reset_n_in) $rose(rail_two_in_sleep_out));
  c_leave_sleep: cover property (@(posedge mclk_in) disable iff (!reset_n_in) $fell(rail_two_in_sleep_out));
  c_decay_write: cover property (@(posedge mclk_in) disable iff (!reset_n_in) $rose(rail_five_decay_select_out));
  c_load_beats_write: cover property (@(posedge mclk_in) disable iff (!reset_n_in) otp_load_in && reg_wr_in);
endmodule
`default_nettype wire

// >>> test/rvs_host_model.sv
// Host model issuing register strobes to the rail voltage select bank
`timescale 1ns/100ps
`default_nettype none
module rvs_host_model (
  input wire logic mclk_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  // Idle bus at time zero
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end

  // One-cycle write strobe; an idle edge passes first so strobes never touch
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'b1;
    reg_addr_out = addr;
    reg_wdata_out = data;
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_wdata_out = ~data;
  endtask

  // One-cycle read strobe after an idle edge; data lands on the strobe's edge
  task automatic rd(input logic [7:0] addr);
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'b1;
    reg_addr_out = addr;
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking testbench for the rail voltage select bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr, rd, hit, otp_load = 1'b0, pin_sel = 1'b0, p1 = 1'b1, p2 = 1'b1, act4 = 1'b0;
  logic [7:0] addr, wdata, rdata, o93 = 8'h00, o94 = 8'h00, o95 = 8'h00, o96 = 8'h00;
  logic [2:0] rng = 3'b000;
  logic [6:0] n2 = 7'h11, t2, c4n, c4s, t4, c5;
  logic s2, d4, r4, d5, r5, r2;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 mclk_in = ~mclk_in;

  rvs_host_model rvs_host_model_inst (.mclk_in(mclk_in), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata));

  rvs_bank #(.FACTORY_RAIL2_SLEEP_CONTROL(8'h5a), .FACTORY_RAIL4_NORMAL_CODE(8'ha5),
    .FACTORY_RAIL4_SLEEP_CODE(8'h50), .FACTORY_RAIL5_NORMAL_CODE(8'h3c)) rvs_bank_inst (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .otp_load_in(otp_load), .otp_rail2_sleep_control_in(o93), .otp_rail4_normal_code_in(o94),
    .otp_rail4_sleep_code_in(o95), .otp_rail5_normal_code_in(o96), .otp_sleep_pin_sel_in(pin_sel),
    .rail_two_range_25mv_in(rng[0]), .rail_four_range_25mv_in(rng[1]),
    .rail_five_range_25mv_in(rng[2]), .rail_two_normal_code_in(n2), .first_sleep_pin_in(p1),
    .second_sleep_pin_in(p2), .rail_four_sleep_active_in(act4), .rail_two_target_code_out(t2),
    .rail_two_in_sleep_out(s2), .rail_four_normal_code_out(c4n), .rail_four_sleep_code_out(c4s),
    .rail_four_target_code_out(t4), .rail_four_decay_select_out(d4),
    .rail_four_range_25mv_out(r4), .rail_five_normal_code_out(c5),
    .rail_five_decay_select_out(d5), .rail_five_range_25mv_out(r5),
    .rail_two_range_25mv_out(r2));

  // Compare one value and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read one offset and check data and hit flag
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rvs_host_model_inst.rd(a);
    chk("rdata", rdata, exp);
    chk("hit", {7'h00, hit}, {7'h00, (a >= 8'h93) && (a <= 8'h96)});
  endtask

  // Let a pin change cross the synchroniser
  task automatic settle();
    repeat (7) @(posedge mclk_in);
    #1;
  endtask

  // Rail two selection outputs
  task automatic chk2(input logic [6:0] code, input logic slp);
    chk("rail two target", {1'b0, t2}, {1'b0, code});
    chk("rail two sleep", {7'h00, s2}, {7'h00, slp});
  endtask

  // Report counts and verdict
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge mclk_in);
    #1;
    reset_n_in = 1'b1;
    rdchk(8'h93, 8'h5a);
    rdchk(8'h94, 8'ha5);
    rdchk(8'h95, 8'h50);
    rdchk(8'h96, 8'h3c);
    // Sleep enable clear: pin low still gives normal code
    p1 = 1'b0;
    settle();
    chk2(7'h11, 1'b0);
    rvs_host_model_inst.wr(8'h93, 8'hb5);
    settle();
    chk2(7'h5a, 1'b1);
    p1 = 1'b1;
    p2 = 1'b0;
    settle();
    chk2(7'h11, 1'b0);
    // Field writes, an idle edge between strobes
    rvs_host_model_inst.wr(8'h94, 8'h2b);
    rvs_host_model_inst.wr(8'h95, 8'hff);
    rvs_host_model_inst.wr(8'h96, 8'h7d);
    chk("rail four code", {1'b0, c4n}, 8'h15);
    chk("rail four decay", {7'h00, d4}, 8'h01);
    chk("rail four sleep", {1'b0, c4s}, 8'h7f);
    chk("rail five code", {1'b0, c5}, 8'h3e);
    chk("rail five decay", {7'h00, d5}, 8'h01);
    rdchk(8'h95, 8'hfe);
    rdchk(8'h94, 8'h2b);
    rdchk(8'h96, 8'h7d);
    rvs_host_model_inst.wr(8'h94, 8'h2a);
    rvs_host_model_inst.wr(8'h96, 8'h7c);
    chk("rail four decay", {7'h00, d4}, 8'h00);
    chk("rail five decay", {7'h00, d5}, 8'h00);
    chk("rail four target", {1'b0, t4}, 8'h15);
    act4 = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("rail four target", {1'b0, t4}, 8'h7f);
    // Unmapped offset
    rvs_host_model_inst.wr(8'h97, 8'hff);
    rdchk(8'h97, 8'h00);
    // Factory load beats a write in the same cycle
    o93 = 8'h67;
    o94 = 8'h81;
    o95 = 8'h43;
    o96 = 8'hfe;
    pin_sel = 1'b1;
    rng = 3'b101;
    otp_load = 1'b1;
    rvs_host_model_inst.wr(8'h94, 8'h00);
    otp_load = 1'b0;
    settle();
    chk2(7'h33, 1'b1);
    rdchk(8'h94, 8'h81);
    rdchk(8'h95, 8'h42);
    chk("ranges", {5'h00, r5, r4, r2}, 8'h05);
    p1 = 1'b0;
    p2 = 1'b1;
    settle();
    chk2(7'h11, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
